// ---- irq_trap_flags.sv ----
// Trap status, peripheral interrupt flags and event interrupt of the core
//
// Behaviour
// - Serial port two event sets flag bit 1
// - Serial port two error sets flag bit 0
// - Flag reads 1 after request, else 0
// - CAN flags stay off without CAN
// - DMA error trap sets control bit 5
// - Acc B catastrophic overflow sets bit 11
// - Acc A overflow bit 14, B bit 13
//
// Local design decisions: the strobed register port and the address map.
`default_nettype none

module irq_trap_flags
  import irq_trap_pkg::*;
#(
  parameter int unsigned ADDR_W  = 4,
  parameter bit          HAS_CAN = 1'b1
) (
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RESET_N,
  // Register port
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic      [DATA_W-1:0] O_RDATA,
  // Trap causes from the core
  input  wire logic              I_ACC_A_OVERFLOW,
  input  wire logic              I_ACC_B_OVERFLOW,
  input  wire logic              I_ACC_A_CATASTROPHIC,
  input  wire logic              I_ACC_B_CATASTROPHIC,
  input  wire logic              I_SHIFT_ERROR,
  input  wire logic              I_DIVIDE_BY_ZERO,
  input  wire logic              I_MATH_ERROR,
  input  wire logic              I_ADDRESS_ERROR,
  input  wire logic              I_STACK_ERROR,
  input  wire logic              I_OSC_FAIL,
  input  wire logic              I_DMA_ERROR_TRAP,
  // Peripheral interrupt requests
  input  wire logic              I_SERIAL_TWO_EVENT,
  input  wire logic              I_SERIAL_TWO_ERROR,
  input  wire logic              I_CAN_EVENT,
  input  wire logic              I_CAN_RECEIVE_READY,
  input  wire logic              I_DMA3_DONE,
  input  wire logic              I_CAPTURE3,
  input  wire logic              I_CAPTURE4,
  input  wire logic [5:0]        I_PAIR_DONE,
  // Outputs to the core
  output logic                   O_IRQ,
  output logic                   O_NEST_DISABLE,
  output logic                   O_ARITH_TRAP
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (ADDR_W < 3 || ADDR_W > 16) begin : g_bad_addr_w
    $error("irq_trap_flags needs ADDR_W between 3 and 16");
  end

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_TRAP   = ADDR_W'(ADDR_TRAP_CTRL);
  localparam logic [ADDR_W-1:0] A_FLAGS2 = ADDR_W'(ADDR_IRQ_FLAGS2);
  localparam logic [ADDR_W-1:0] A_PAIR   = ADDR_W'(ADDR_PAIR_DONE);
  localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'(ADDR_EVT_STATUS);
  localparam logic [ADDR_W-1:0] A_MASK   = ADDR_W'(ADDR_EVT_MASK);

  // Without a CAN controller its flag bits are removed from the bank
  localparam logic [15:0] FLAGS2_IMPL = HAS_CAN ? IF2_IMPL_MASK
                                                : (IF2_IMPL_MASK & ~IF2_CAN_MASK);

  logic wr_trap;
  logic wr_flags2;
  logic wr_pair;

  // Write strobes per register
  always_comb begin
    wr_trap   = 1'b0;
    wr_flags2 = 1'b0;
    wr_pair   = 1'b0;
    if (I_WR && I_ADDR == A_TRAP) begin
      wr_trap = 1'b1;
    end else if (I_WR && I_ADDR == A_FLAGS2) begin
      wr_flags2 = 1'b1;
    end else if (I_WR && I_ADDR == A_PAIR) begin
      wr_pair = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Flag set vectors
  // ------------------------------------------------------------------
  logic [15:0] trap_q;
  logic [15:0] trap_set;
  logic [15:0] flags2_q;
  logic [15:0] flags2_set;
  logic [15:0] pair_q;
  logic [15:0] pair_set;

  // Overflow flags record a trap, so they need the matching enable
  always_comb begin
    trap_set                = RESET_ZERO;
    trap_set[TC_OVA_FLAG]   = I_ACC_A_OVERFLOW & trap_q[TC_OVA_EN];
    trap_set[TC_OVB_FLAG]   = I_ACC_B_OVERFLOW & trap_q[TC_OVB_EN];
    trap_set[TC_COVA_FLAG]  = I_ACC_A_CATASTROPHIC & trap_q[TC_COV_EN];
    trap_set[TC_COVB_FLAG]  = I_ACC_B_CATASTROPHIC & trap_q[TC_COV_EN];
    trap_set[TC_SHIFT_ERR]  = I_SHIFT_ERROR;
    trap_set[TC_DIV0_ERR]   = I_DIVIDE_BY_ZERO;
    trap_set[TC_DMA_ERR]    = I_DMA_ERROR_TRAP;
    trap_set[TC_MATH_ERR]   = I_MATH_ERROR | I_SHIFT_ERROR | I_DIVIDE_BY_ZERO;
    trap_set[TC_ADDR_ERR]   = I_ADDRESS_ERROR;
    trap_set[TC_STACK_ERR]  = I_STACK_ERROR;
    trap_set[TC_OSC_FAIL]   = I_OSC_FAIL;
  end

  // Peripheral requests into their flag positions
  always_comb begin
    flags2_set              = RESET_ZERO;
    flags2_set[IF2_SER_ERR] = I_SERIAL_TWO_ERROR;
    flags2_set[IF2_SER_EVT] = I_SERIAL_TWO_EVENT;
    flags2_set[IF2_CAN_RX]  = I_CAN_RECEIVE_READY & HAS_CAN;
    flags2_set[IF2_CAN_EVT] = I_CAN_EVENT & HAS_CAN;
    flags2_set[IF2_DMA3]    = I_DMA3_DONE;
    flags2_set[IF2_CAP3]    = I_CAPTURE3;
    flags2_set[IF2_CAP4]    = I_CAPTURE4;
    pair_set                = {10'h000, I_PAIR_DONE};
  end

  // ------------------------------------------------------------------
  // Flag registers
  // ------------------------------------------------------------------
  // Control bits ride in the trap bank with no set source
  flag_bank #(
    .WIDTH (DATA_W),
    .IMPL  (TC_IMPL_MASK)
  ) u_trap_bank (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RESET_N),
    .i_set   (trap_set),
    .i_wr    (wr_trap),
    .i_wdata (I_WDATA),
    .o_q     (trap_q)
  );

  // Peripheral flags two
  flag_bank #(
    .WIDTH (DATA_W),
    .IMPL  (FLAGS2_IMPL)
  ) u_flags2_bank (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RESET_N),
    .i_set   (flags2_set),
    .i_wr    (wr_flags2),
    .i_wdata (I_WDATA),
    .o_q     (flags2_q)
  );

  // Converter pair done flags
  flag_bank #(
    .WIDTH (DATA_W),
    .IMPL  (PAIR_IMPL_MASK)
  ) u_pair_bank (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RESET_N),
    .i_set   (pair_set),
    .i_wr    (wr_pair),
    .i_wdata (I_WDATA),
    .o_q     (pair_q)
  );

  // ------------------------------------------------------------------
  // Block state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] mask;
    logic              irq;
    logic              nest_dis;
    logic              arith_trap;
  } top_state_t;

  top_state_t  state;
  top_state_t  next_state;
  logic [15:0] events;

  // Event vector: any new flag request, grouped per register
  always_comb begin
    events                              = RESET_ZERO;
    events[EV_IF2_LSB +: 7]             = flags2_set[6:0];
    events[EV_PAIR_LSB +: PAIR_COUNT]   = pair_set[PAIR_COUNT-1:0];
    events[EV_TRAP]                     = |trap_set;
  end

  // ------------------------------------------------------------------
  // Next state: read data, status, mask, outputs
  // ------------------------------------------------------------------
  // Read data stands only in the cycle after the strobe; unmapped reads 0
  always_comb begin
    next_state       = state;
    next_state.rdata = RESET_ZERO;
    if (I_RD) begin
      if (I_ADDR == A_TRAP) begin
        next_state.rdata = trap_q;
      end else if (I_ADDR == A_FLAGS2) begin
        next_state.rdata = flags2_q;
      end else if (I_ADDR == A_PAIR) begin
        next_state.rdata = pair_q;
      end else if (I_ADDR == A_STATUS) begin
        next_state.rdata = state.status;
      end else if (I_ADDR == A_MASK) begin
        next_state.rdata = state.mask;
      end
    end

    // Read clears status, an event in the same cycle still lands
    if (I_RD && I_ADDR == A_STATUS) begin
      next_state.status = RESET_ZERO;
    end
    next_state.status = (next_state.status | events) & EV_IMPL_MASK;

    if (I_WR && I_ADDR == A_MASK) begin
      next_state.mask = I_WDATA & EV_IMPL_MASK;
    end

    // IRQ and nest disable follow the next register values; arith trap uses old flags and new sets, not a same-cycle write
    next_state.irq        = |(next_state.status & next_state.mask);
    next_state.nest_dis   = wr_trap ? I_WDATA[TC_NEST_DIS] : trap_q[TC_NEST_DIS];
    next_state.arith_trap = |(trap_q[TC_OVA_FLAG:TC_COVB_FLAG]
                              | trap_set[TC_OVA_FLAG:TC_COVB_FLAG]);
  end

  // Single state register
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // Outputs straight from flip-flops
  // ------------------------------------------------------------------
  assign O_RDATA        = state.rdata;
  assign O_IRQ          = state.irq;
  assign O_NEST_DISABLE = state.nest_dis;
  assign O_ARITH_TRAP   = state.arith_trap;

endmodule

`default_nettype wire

// ---- irq_trap_pkg.sv ----
// Package of offsets, field positions and reset values for the trap and interrupt flag block
`default_nettype none

package irq_trap_pkg;

  // ------------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W = 16;

  // ------------------------------------------------------------------
  // Register indices on the plain register port
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_TRAP_CTRL  = 4'h0; // trap_and_nesting_control
  localparam logic [3:0] ADDR_IRQ_FLAGS2 = 4'h1; // peripheral_irq_flags_two
  localparam logic [3:0] ADDR_PAIR_DONE  = 4'h2; // converter_pair_done_flags
  localparam logic [3:0] ADDR_EVT_STATUS = 4'h3; // sticky event status, read clears
  localparam logic [3:0] ADDR_EVT_MASK   = 4'h4; // event mask, same layout

  // ------------------------------------------------------------------
  // trap_and_nesting_control fields
  // ------------------------------------------------------------------
  localparam int unsigned TC_NEST_DIS   = 15;
  localparam int unsigned TC_OVA_FLAG   = 14; // acc_a_overflow_trap_flag
  localparam int unsigned TC_OVB_FLAG   = 13; // acc_b_overflow_trap_flag
  localparam int unsigned TC_COVA_FLAG  = 12;
  localparam int unsigned TC_COVB_FLAG  = 11; // acc_b_catastrophic_overflow_flag
  localparam int unsigned TC_OVA_EN     = 10;
  localparam int unsigned TC_OVB_EN     = 9;
  localparam int unsigned TC_COV_EN     = 8;
  localparam int unsigned TC_SHIFT_ERR  = 7;
  localparam int unsigned TC_DIV0_ERR   = 6;
  localparam int unsigned TC_DMA_ERR    = 5; // dma_error_trap_status
  localparam int unsigned TC_MATH_ERR   = 4;
  localparam int unsigned TC_ADDR_ERR   = 3;
  localparam int unsigned TC_STACK_ERR  = 2;
  localparam int unsigned TC_OSC_FAIL   = 1;
  localparam logic [15:0] TC_IMPL_MASK  = 16'hFFFE;

  // ------------------------------------------------------------------
  // peripheral_irq_flags_two fields
  // ------------------------------------------------------------------
  localparam int unsigned IF2_SER_ERR   = 0; // serial_port_two_error_flag
  localparam int unsigned IF2_SER_EVT   = 1; // serial_port_two_event_flag
  localparam int unsigned IF2_CAN_RX    = 2; // can_receive_ready_flag
  localparam int unsigned IF2_CAN_EVT   = 3; // can_event_flag
  localparam int unsigned IF2_DMA3      = 4;
  localparam int unsigned IF2_CAP3      = 5;
  localparam int unsigned IF2_CAP4      = 6;
  localparam logic [15:0] IF2_IMPL_MASK = 16'h007F;
  localparam logic [15:0] IF2_CAN_MASK  = 16'h000C;

  // ------------------------------------------------------------------
  // converter_pair_done_flags: pairs 2..7 in bits 0..5
  // ------------------------------------------------------------------
  localparam int unsigned PAIR_COUNT     = 6;
  localparam logic [15:0] PAIR_IMPL_MASK = 16'h003F;

  // ------------------------------------------------------------------
  // Event status layout
  // ------------------------------------------------------------------
  localparam int unsigned EV_IF2_LSB  = 0;  // bits 6:0 mirror flag set events
  localparam int unsigned EV_PAIR_LSB = 8;  // bits 13:8 converter pairs
  localparam int unsigned EV_TRAP     = 14; // any trap flag set
  localparam logic [15:0] EV_IMPL_MASK = 16'h7F7F;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] RESET_ZERO = 16'h0000;

endpackage

`default_nettype wire

// ---- flag_bank.sv ----
// Bank of hardware-set, software-written flag bits
`default_nettype none

module flag_bank
  import irq_trap_pkg::*;
#(
  parameter int unsigned      WIDTH = 16,
  parameter logic [WIDTH-1:0] IMPL  = '1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic             i_wr,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic      [WIDTH-1:0] o_q
);

  // Elaboration check: a bank wider than the bus cannot be read back
  if (WIDTH < 1 || WIDTH > DATA_W) begin : g_bad_width
    $error("flag_bank width out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] q;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  // ------------------------------------------------------------------
  // Next value
  // ------------------------------------------------------------------
  // Set beats a simultaneous write of 0 so no event is lost
  always_comb begin
    next_state   = state;
    if (i_wr) begin
      next_state.q = i_wdata;
    end
    next_state.q = (next_state.q | i_set) & IMPL;
  end

  // Register, synchronous active-low reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_q = state.q;

endmodule

`default_nettype wire

// ---- irq_trap_flags_sva.sv ----
// Assertion checker for the trap and interrupt flag block
`default_nettype none

module irq_trap_flags_sva
  import irq_trap_pkg::*;
#(
  parameter int unsigned ADDR_W  = 4,
  parameter bit          HAS_CAN = 1'b1
) (
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RESET_N,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  input  wire logic [DATA_W-1:0] O_RDATA,
  input  wire logic              I_ACC_A_OVERFLOW,
  input  wire logic              I_ACC_B_OVERFLOW,
  input  wire logic              I_ACC_B_CATASTROPHIC,
  input  wire logic              I_DMA_ERROR_TRAP,
  input  wire logic              I_SERIAL_TWO_EVENT,
  input  wire logic              I_SERIAL_TWO_ERROR,
  input  wire logic              O_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  // ------------------------------------------------------------------
  // Shadows of trap enables and the serial event mask bit
  // ------------------------------------------------------------------
  logic [2:0] en;
  logic       msk;
  // Follow software writes only, so the shadow never runs ahead
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      en  <= 3'h0;
      msk <= 1'b0;
    end else if (I_WR && I_ADDR == ADDR_TRAP_CTRL) begin
      en <= I_WDATA[10:8];
    end else if (I_WR && I_ADDR == ADDR_EVT_MASK) begin
      msk <= I_WDATA[IF2_SER_EVT];
    end
  end
  // Read strobe at a register index
  sequence rd_at(a);
    I_RD && I_ADDR == a;
  endsequence
  // Event, then the earliest read that must already see it
  property flag_seen(ev, a, b);
    ev ##1 rd_at(a) |=> O_RDATA[b];
  endproperty
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_rdata_idle: assert property (!I_RD |=> O_RDATA == '0)
    else $error("read data not zero outside a read");
  a_unmapped_read: assert property (I_RD && I_ADDR > ADDR_EVT_MASK |=> O_RDATA == '0)
    else $error("unmapped read not zero");
  a_ser_event_flag:
    assert property (flag_seen(I_SERIAL_TWO_EVENT, ADDR_IRQ_FLAGS2, IF2_SER_EVT))
    else $error("serial event flag missing");
  a_ser_error_flag:
    assert property (flag_seen(I_SERIAL_TWO_ERROR, ADDR_IRQ_FLAGS2, IF2_SER_ERR))
    else $error("serial error flag missing");
  a_can_flags_off:
    assert property (!HAS_CAN && I_RD && I_ADDR == ADDR_IRQ_FLAGS2 |=> O_RDATA[3:2] == 2'b00)
    else $error("CAN flags seen without CAN");
  a_dma_err_flag:
    assert property (flag_seen(I_DMA_ERROR_TRAP, ADDR_TRAP_CTRL, TC_DMA_ERR))
    else $error("DMA error status missing");
  a_covb_flag:
    assert property (flag_seen(I_ACC_B_CATASTROPHIC && en[0], ADDR_TRAP_CTRL, TC_COVB_FLAG))
    else $error("acc B catastrophic flag missing");
  a_ova_flag:
    assert property (flag_seen(I_ACC_A_OVERFLOW && en[2], ADDR_TRAP_CTRL, TC_OVA_FLAG))
    else $error("acc A overflow flag missing");
  a_ovb_flag:
    assert property (flag_seen(I_ACC_B_OVERFLOW && en[1], ADDR_TRAP_CTRL, TC_OVB_FLAG))
    else $error("acc B overflow flag missing");
  a_irq_unmasked: assert property (
    I_SERIAL_TWO_EVENT && msk && !(I_WR && I_ADDR == ADDR_EVT_MASK) |=> O_IRQ)
    else $error("unmasked event gave no interrupt");
endmodule

`default_nettype wire

// ---- event_source.sv ----
// Model of the core and peripherals that raise trap and request lines
`default_nettype none

module event_source (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [23:0] i_req,
  input  wire logic        i_fire,
  output logic      [23:0] o_src
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // One-cycle pulses; a source never holds its line
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_src <= 24'h000000;
    end else begin
      o_src <= i_fire ? i_req : 24'h000000;
    end
  end
endmodule

`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the trap and interrupt flag block
`default_nettype none

module testbench
  import irq_trap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              I_REF_CLK = 1'b0;
  logic              I_RESET_N = 1'b0;
  logic [3:0]        I_ADDR    = 4'h0;
  logic [DATA_W-1:0] I_WDATA   = 16'h0000;
  logic              I_WR      = 1'b0;
  logic              I_RD      = 1'b0;
  logic [23:0]       req       = 24'h000000;
  logic              fire      = 1'b0;
  logic [23:0]       src;
  logic [15:0]       rdq [2];
  logic [15:0]       nc;
  logic [1:0]        irq, nest, arith;
  int                mismatches = 0;
  int                tests_run  = 0;
  int                sidx [11]  = '{0, 1, 2, 3, 10, 4, 5, 6, 7, 8, 9};
  logic [15:0]       tbit [11]  = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0020,
                                    16'h0090, 16'h0050, 16'h0010, 16'h0008, 16'h0004, 16'h0002};
  // ------------------------------------------------------------------
  // Clock, partner and the two design copies
  // ------------------------------------------------------------------
  initial begin
    forever #25 I_REF_CLK = ~I_REF_CLK;
  end
  event_source event_source_inst (.i_clk(I_REF_CLK), .i_rst_n(I_RESET_N), .i_req(req),
    .i_fire(fire), .o_src(src));
  // Second copy is built without CAN; both see the same traffic
  for (genvar g = 0; g < 2; g++) begin : gen_dut
    irq_trap_flags #(.HAS_CAN(g == 0)) irq_trap_flags_inst (
      .I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR),
      .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(rdq[g]),
      .I_ACC_A_OVERFLOW(src[0]), .I_ACC_B_OVERFLOW(src[1]),
      .I_ACC_A_CATASTROPHIC(src[2]), .I_ACC_B_CATASTROPHIC(src[3]),
      .I_SHIFT_ERROR(src[4]), .I_DIVIDE_BY_ZERO(src[5]), .I_MATH_ERROR(src[6]),
      .I_ADDRESS_ERROR(src[7]), .I_STACK_ERROR(src[8]), .I_OSC_FAIL(src[9]),
      .I_DMA_ERROR_TRAP(src[10]), .I_SERIAL_TWO_ERROR(src[11]),
      .I_SERIAL_TWO_EVENT(src[12]), .I_CAN_RECEIVE_READY(src[13]),
      .I_CAN_EVENT(src[14]), .I_DMA3_DONE(src[15]), .I_CAPTURE3(src[16]),
      .I_CAPTURE4(src[17]), .I_PAIR_DONE(src[23:18]), .O_IRQ(irq[g]),
      .O_NEST_DISABLE(nest[g]), .O_ARITH_TRAP(arith[g]));
  end
  // ------------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Extra idle cycle keeps a strobe from being driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    I_ADDR  <= a;
    I_WDATA <= d;
    I_WR    <= 1'b1;
    @(posedge I_REF_CLK);
    I_WR <= 1'b0;
    @(posedge I_REF_CLK);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    I_ADDR <= a;
    I_RD   <= 1'b1;
    @(posedge I_REF_CLK);
    I_RD <= 1'b0;
    @(negedge I_REF_CLK);
    nc = rdq[1];
    check(rdq[0], exp);
    @(posedge I_REF_CLK);
  endtask
  // Levels are sampled mid-cycle, once the edge's updates have landed
  task automatic outs(input logic [2:0] exp);
    @(negedge I_REF_CLK);
    check({13'h0, irq[0], nest[0], arith[0]}, {13'h0, exp});
    check({13'h0, irq[1], nest[1], arith[1]}, {13'h0, exp});
    @(posedge I_REF_CLK);
  endtask
  task automatic pulse(input logic [23:0] v);
    req  <= v;
    fire <= 1'b1;
    @(posedge I_REF_CLK);
    fire <= 1'b0;
    @(posedge I_REF_CLK);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge I_REF_CLK);
    I_RESET_N <= 1'b1;
    @(posedge I_REF_CLK);
    for (int a = 0; a < 8; a++) begin
      rd(4'(a), 16'h0000);
    end
    outs(3'b000);
    $display("Test reset done");
    for (int i = 0; i < 7; i++) begin
      pulse(24'h000800 << i);
      rd(ADDR_IRQ_FLAGS2, 16'h0001 << i);
      check(nc, (i == 2 || i == 3) ? 16'h0000 : 16'h0001 << i);
      wr(ADDR_IRQ_FLAGS2, 16'h0000);
      rd(ADDR_IRQ_FLAGS2, 16'h0000);
    end
    for (int j = 0; j < 6; j++) begin
      pulse(24'h040000 << j);
      rd(ADDR_PAIR_DONE, 16'h0001 << j);
      wr(ADDR_PAIR_DONE, 16'h0000);
    end
    $display("Test peripheral flags done");
    // Overflow with its enable off leaves the flag clear
    pulse(24'h000001);
    rd(ADDR_TRAP_CTRL, 16'h0000);
    for (int k = 0; k < 11; k++) begin
      wr(ADDR_TRAP_CTRL, 16'h8700);
      pulse(24'h000001 << sidx[k]);
      rd(ADDR_TRAP_CTRL, 16'h8700 | tbit[k]);
      outs({2'b01, k < 4});
    end
    $display("Test trap flags done");
    wr(ADDR_EVT_MASK, 16'h0002);
    outs(3'b110);
    rd(ADDR_EVT_STATUS, 16'h7F7F);
    outs(3'b010);
    pulse(24'h001000);
    outs(3'b110);
    rd(ADDR_EVT_STATUS, 16'h0002);
    pulse(24'h000800);
    outs(3'b010);
    rd(ADDR_EVT_STATUS, 16'h0001);
    $display("Test interrupt done");
    results();
  end
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge I_REF_CLK);
    mismatches++;
    $display("[FAIL] %0t run did not finish", $time);
    results();
  end
endmodule

bind irq_trap_flags irq_trap_flags_sva #(.ADDR_W(ADDR_W), .HAS_CAN(HAS_CAN))
  irq_trap_flags_sva_inst (.I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_ACC_A_OVERFLOW(I_ACC_A_OVERFLOW), .I_ACC_B_OVERFLOW(I_ACC_B_OVERFLOW),
  .I_ACC_B_CATASTROPHIC(I_ACC_B_CATASTROPHIC), .I_DMA_ERROR_TRAP(I_DMA_ERROR_TRAP),
  .I_SERIAL_TWO_EVENT(I_SERIAL_TWO_EVENT), .I_SERIAL_TWO_ERROR(I_SERIAL_TWO_ERROR),
  .O_IRQ(O_IRQ));

`default_nettype wire
